// [logic/acpod_top.sv]
/*
 * Digital control and output demux of an 8-bit dual-edge sampling converter:
 * pin mode decode, extended control serial load, calibration trigger,
 * power down, sample capture, 1:4 / 1:2 output demux and data clock.
 * Assumes all pins are asynchronous to clk_sys; three-level pins arrive as a
 * logic level plus a mid-level (floating or half supply) detect; laneReady
 * comes from capture logic on clk_sys.
 */
// Behaviour
// - Sample on both input clock edges
// - Output codes are offset binary
// - Default mode spreads samples over four lanes
// - Two-way mode uses only lanes c, d
// - Calibrate after 80 low, 80 high cycles
// - Power-down input high holds power down
// - Range pin low 600 mV, high 800 mV
// - Range pin mid-level enters extended control
// - Swing pin becomes serial clock in extended
// - Edge pin becomes serial data in extended
// - Edge pin picks edge; mid selects DDR
// - Resync pulse resets output data clock
// - Resync pin active when config bit14 zero
`timescale 1ns/100ps
module acpod_top (
   input  wire logic                         clk_sys,
   input  wire logic                         arst_n,
   input  wire logic                         sampleClock,
   input  wire logic [acpod_pkg::SAMPLE_W-1:0] sampleCode,
   input  wire logic                         rangeOrExtctlSelect,
   input  wire logic                         rangeOrExtctlSelectMid,
   input  wire logic                         outputSwingSelect,
   input  wire logic                         outputEdgeSelect,
   input  wire logic                         outputEdgeSelectMid,
   input  wire logic                         outputClockResync,
   input  wire logic                         powerDownInput,
   input  wire logic                         calTrigger,
   input  wire logic                         laneReady,
   output logic [acpod_pkg::SAMPLE_W-1:0]    outputLaneA,
   output logic [acpod_pkg::SAMPLE_W-1:0]    outputLaneB,
   output logic [acpod_pkg::SAMPLE_W-1:0]    outputLaneC,
   output logic [acpod_pkg::SAMPLE_W-1:0]    outputLaneD,
   output logic                              laneValid,
   output logic                              outputDataClock,
   output logic                              calStart,
   output logic                              powerDownActive,
   output logic                              extendedMode,
   output logic                              fullScale800,
   output logic                              outputSwingHigh,
   output logic                              ddrMode,
   output logic                              demux2Mode,
   output logic                              sampleOverrun,
   output logic [acpod_pkg::CFG_W-1:0]       configWord
);
   import acpod_pkg::*;

   logic [1:0]          rstPipe;
   logic                rst_n;
   logic [SYNC_W-1:0]   syncIn;
   logic [SYNC_W-1:0]   syncOut;
   logic                sclkS;
   logic [SAMPLE_W-1:0] codeS;
   logic                rangeS;
   logic                rangeMidS;
   logic                swingS;
   logic                edgeS;
   logic                edgeMidS;
   logic                resyncS;
   logic                pdS;
   logic                calS;
   logic                sclkPrev;
   logic                sampleEdge;
   logic                sclkRise;
   logic                serClkPrev;
   logic                serClkRise;
   logic [CFG_W-2:0]    serShift;
   logic [3:0]          serCount;
   logic                edgeRising;
   logic                resyncActive;
   logic                fifoInReady;
   logic                fifoOutValid;
   logic                fifoOutReady;
   logic [SAMPLE_W-1:0] fifoOutData;
   logic [SAMPLE_W-1:0] pushData;
   logic [SAMPLE_W-1:0] stage   [LANES];
   logic [SAMPLE_W-1:0] laneOut [LANES];
   logic [1:0]          slot;
   logic [1:0]          slotLast;
   logic [1:0]          stageIdx;
   logic                groupFull;
   logic                emitWord;
   logic                clkHalf;
   acpod_cal_e          calState;
   logic [6:0]          calCount;

   // Reset release through two flip-flops
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rst_n = rstPipe[1];

   assign syncIn = {sampleClock, sampleCode, rangeOrExtctlSelect, rangeOrExtctlSelectMid,
                    outputSwingSelect, outputEdgeSelect, outputEdgeSelectMid,
                    outputClockResync, powerDownInput, calTrigger};

   acpod_sync #(.W(SYNC_W)) u_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (syncIn),
      .q     (syncOut)
   );

   assign {sclkS, codeS, rangeS, rangeMidS, swingS, edgeS, edgeMidS,
           resyncS, pdS, calS} = syncOut;

   // Mode decode
   assign extendedMode    = rangeMidS;
   assign fullScale800    = extendedMode ? configWord[CFG_RANGE_BIT] : rangeS;
   assign ddrMode         = extendedMode ? configWord[CFG_DDR_BIT] : edgeMidS;
   assign edgeRising      = extendedMode ? configWord[CFG_EDGE_BIT] : edgeS;
   assign demux2Mode      = extendedMode & configWord[CFG_DEMUX2_BIT];
   assign outputSwingHigh = extendedMode | swingS;
   assign powerDownActive = pdS;
   assign resyncActive    = resyncS & (~extendedMode | ~configWord[CFG_RESYNC_SRC_BIT]);

   // Input clock edge finding
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclkPrev   <= 1'b0;
         serClkPrev <= 1'b0;
      end else begin
         sclkPrev   <= sclkS;
         serClkPrev <= swingS;
      end
   end
   assign sampleEdge = sclkS ^ sclkPrev;
   assign sclkRise   = sclkS & ~sclkPrev;
   assign serClkRise = extendedMode & swingS & ~serClkPrev;

   // Serial load of the configuration word in extended control mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         serShift   <= '0;
         serCount   <= 4'h0;
         configWord <= CFG_RESET;
      end else if (!extendedMode) begin
         serCount <= 4'h0;
      end else if (serClkRise) begin
         serShift <= {serShift[CFG_W-3:0], edgeS};
         serCount <= serCount + 4'h1;
         if (serCount == CFG_LAST_BIT) begin
            configWord <= {serShift, edgeS};
         end
      end
   end

   // Calibration trigger qualification in input clock cycles
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         calState <= CAL_WAIT_LOW;
         calCount <= 7'h00;
         calStart <= 1'b0;
      end else begin
         calStart <= 1'b0;
         case (calState)
            CAL_WAIT_LOW: begin
               calCount <= 7'h00;
               if (!calS) begin
                  calState <= CAL_LOW;
               end
            end
            CAL_LOW: begin
               if (calS) begin
                  calCount <= 7'h00;
                  calState <= (calCount >= CAL_MIN_CYCLES) ? CAL_HIGH : CAL_WAIT_LOW;
               end else if (sclkRise && calCount < CAL_MIN_CYCLES) begin
                  calCount <= calCount + 7'h01;
               end
            end
            CAL_HIGH: begin
               if (!calS) begin
                  calCount <= 7'h00;
                  calState <= CAL_LOW;
               end else if (sclkRise) begin
                  calCount <= calCount + 7'h01;
                  if (calCount + 7'h01 >= CAL_MIN_CYCLES) begin
                     calStart <= 1'b1;
                     calState <= CAL_WAIT_LOW;
                  end
               end
            end
            default: begin
               calState <= CAL_WAIT_LOW;
               calCount <= 7'h00;
            end
         endcase
      end
   end

   // Sample capture into the FIFO, offset binary coding
   assign pushData = {~codeS[SAMPLE_W-1], codeS[SAMPLE_W-2:0]};

   acpod_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk      (clk_sys),
      .rst_n    (rst_n),
      .flush    (pdS),
      .inValid  (sampleEdge & ~pdS),
      .inReady  (fifoInReady),
      .inData   (pushData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sampleOverrun <= 1'b0;
      end else begin
         sampleOverrun <= sampleEdge & ~pdS & ~fifoInReady;
      end
   end

   // Demux gathering
   assign slotLast     = demux2Mode ? SLOT_LAST_2 : SLOT_LAST_4;
   assign stageIdx     = demux2Mode ? slot + SLOT_OFFSET_2 : slot;
   assign fifoOutReady = ~pdS & ~resyncActive & ~groupFull;
   assign emitWord     = groupFull & laneReady & ~pdS & ~resyncActive;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot      <= 2'h0;
         groupFull <= 1'b0;
      end else if (pdS || resyncActive) begin
         slot      <= 2'h0;
         groupFull <= 1'b0;
      end else begin
         if (emitWord) begin
            groupFull <= 1'b0;
         end
         if (fifoOutValid && fifoOutReady) begin
            if (slot == slotLast) begin
               slot      <= 2'h0;
               groupFull <= 1'b1;
            end else begin
               slot <= slot + 2'h1;
            end
         end
      end
   end

   // Staging and output registers, one per lane
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            stage[i]   <= '0;
            laneOut[i] <= '0;
         end else if (pdS) begin
            stage[i]   <= '0;
            laneOut[i] <= '0;
         end else begin
            if (fifoOutValid && fifoOutReady && stageIdx == i) begin
               stage[i] <= fifoOutData;
            end
            if (emitWord) begin
               laneOut[i] <= (demux2Mode && i < 2) ? '0 : stage[i];
            end
         end
      end
   end

   assign outputLaneA = laneOut[0];
   assign outputLaneB = laneOut[1];
   assign outputLaneC = laneOut[2];
   assign outputLaneD = laneOut[3];

   // Output word strobe and data clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         laneValid       <= 1'b0;
         outputDataClock <= 1'b0;
         clkHalf         <= 1'b0;
      end else if (pdS || resyncActive) begin
         laneValid       <= 1'b0;
         outputDataClock <= 1'b0;
         clkHalf         <= 1'b0;
      end else begin
         laneValid <= emitWord;
         clkHalf   <= emitWord & ~ddrMode;
         if (emitWord) begin
            outputDataClock <= ddrMode ? ~outputDataClock : edgeRising;
         end else if (clkHalf) begin
            outputDataClock <= ~edgeRising;
         end
      end
   end
endmodule : acpod_top

// [logic/acpod_pkg.sv]
/*
 * Constants shared by the converter control and output demux block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acpod_pkg;
   localparam int          SAMPLE_W           = 8;
   localparam int          FIFO_DEPTH         = 4;
   localparam int          LANES              = 4;
   localparam int          SYNC_W             = 17;
   localparam int          CFG_W              = 16;
   localparam logic [6:0]  CAL_MIN_CYCLES     = 7'h50;
   localparam logic [3:0]  CFG_LAST_BIT       = 4'hF;
   localparam logic [15:0] CFG_RESET          = 16'h0000;
   localparam int          CFG_RANGE_BIT      = 0;
   localparam int          CFG_EDGE_BIT       = 1;
   localparam int          CFG_DDR_BIT        = 2;
   localparam int          CFG_DEMUX2_BIT     = 3;
   localparam int          CFG_RESYNC_SRC_BIT = 14;
   localparam logic [1:0]  SLOT_LAST_4        = 2'h3;
   localparam logic [1:0]  SLOT_LAST_2        = 2'h1;
   localparam logic [1:0]  SLOT_OFFSET_2      = 2'h2;

   typedef enum logic [2:0] {
      CAL_WAIT_LOW = 3'h1,
      CAL_LOW      = 3'h2,
      CAL_HIGH     = 3'h4
   } acpod_cal_e;
endpackage : acpod_pkg

// [logic/acpod_sync.sv]
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level or is only used for edge finding.
 */
`timescale 1ns/100ps
module acpod_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : acpod_sync

// [logic/acpod_fifo.sv]
/*
 * Small flip-flop FIFO with valid/ready on both sides and a flush.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/100ps
module acpod_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   logic             doPush;
   logic             doPop;

   assign inReady  = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
   assign outValid = (wrPtr != rdPtr);
   assign outData  = mem[rdPtr[AW-1:0]];
   assign doPush   = inValid && inReady && !flush;
   assign doPop    = outValid && outReady && !flush;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (doPop) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule : acpod_fifo

// [dv/acpod_top_asserts.sv]
/* Assertions on the ports of acpod_top.
   Assumes a bind from the bench; a pin held five cycles counts as settled. */
`timescale 1ns/100ps
module acpod_top_asserts (
   input wire logic                         clk_sys,
   input wire logic                         arst_n,
   input wire logic                         rangeOrExtctlSelect,
   input wire logic                         rangeOrExtctlSelectMid,
   input wire logic                         outputEdgeSelectMid,
   input wire logic                         outputClockResync,
   input wire logic                         powerDownInput,
   input wire logic [acpod_pkg::SAMPLE_W-1:0] outputLaneA,
   input wire logic [acpod_pkg::SAMPLE_W-1:0] outputLaneB,
   input wire logic                         laneValid,
   input wire logic                         outputDataClock,
   input wire logic                         calStart,
   input wire logic                         powerDownActive,
   input wire logic                         extendedMode,
   input wire logic                         fullScale800,
   input wire logic                         ddrMode,
   input wire logic                         demux2Mode,
   input wire logic [acpod_pkg::CFG_W-1:0]  configWord
);
   import acpod_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence s_plain_pins;
      (!rangeOrExtctlSelectMid && $stable(rangeOrExtctlSelect))[*5];
   endsequence
   sequence s_resync_held;
      (outputClockResync && (!rangeOrExtctlSelectMid || !configWord[CFG_RESYNC_SRC_BIT]))[*5];
   endsequence
   a_power_follows: assert property (powerDownInput[*5] |-> powerDownActive)
      else $error("power down not entered");
   a_power_quiet: assert property (
      powerDownActive[*2] |-> !laneValid && outputLaneA == '0 && outputLaneB == '0)
      else $error("lanes active in power down");
   a_range_pin: assert property (
      s_plain_pins |-> fullScale800 == rangeOrExtctlSelect && !extendedMode && !demux2Mode)
      else $error("range select wrong");
   a_ext_enter: assert property (rangeOrExtctlSelectMid[*5] |-> extendedMode)
      else $error("extended mode not entered");
   a_ext_config: assert property (extendedMode |-> fullScale800 == configWord[CFG_RANGE_BIT]
      && ddrMode == configWord[CFG_DDR_BIT] && demux2Mode == configWord[CFG_DEMUX2_BIT])
      else $error("modes not from config");
   a_ddr_pin: assert property (
      (!rangeOrExtctlSelectMid && outputEdgeSelectMid)[*5] |-> ddrMode)
      else $error("mid edge pin did not select ddr");
   a_ddr_toggle: assert property (laneValid && ddrMode |-> $changed(outputDataClock))
      else $error("data clock did not toggle");
   a_resync_clk: assert property (s_resync_held |-> !outputDataClock)
      else $error("data clock not held by resync");
   a_cal_single: assert property (calStart |=> (!calStart)[*8])
      else $error("calibration start repeated");
   a_demux2_ab: assert property (laneValid && demux2Mode |-> outputLaneA == '0
      && outputLaneB == '0)
      else $error("lanes a b used in two-way mode");
   a_cfg_hold: assert property ((!extendedMode)[*3] |-> $stable(configWord))
      else $error("config changed outside extended mode");
endmodule : acpod_top_asserts

// [dv/acpod_capture_model.sv]
/* Capture logic model that takes lane words from acpod_top.
   Assumes lanes and laneValid are registered on clk_sys. */
`timescale 1ns/100ps
module acpod_capture_model (
   input wire logic                          clk_sys,
   input wire logic                          arst_n,
   input wire logic                          stall,
   input wire logic                          laneValid,
   input wire logic [acpod_pkg::SAMPLE_W-1:0] outputLaneA,
   input wire logic [acpod_pkg::SAMPLE_W-1:0] outputLaneB,
   input wire logic [acpod_pkg::SAMPLE_W-1:0] outputLaneC,
   input wire logic [acpod_pkg::SAMPLE_W-1:0] outputLaneD,
   output logic                              laneReady,
   output logic [31:0]                       lastWord,
   output logic [15:0]                       words
);
   import acpod_pkg::*;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         laneReady <= 1'b0;
         lastWord  <= 32'h0;
         words     <= 16'h0;
      end else begin
         laneReady <= !stall;
         if (laneValid) begin
            lastWord <= {outputLaneA, outputLaneB, outputLaneC, outputLaneD};
            words    <= words + 16'h1;
         end
      end
   end
endmodule : acpod_capture_model

// [dv/acpod_top_tb.sv]
/* Self-checking bench for acpod_top with a capture model on the lanes.
   Assumes the package, the design, the model and the checker are compiled first. */
`timescale 1ns/100ps
module acpod_top_tb;
   import acpod_pkg::*;
   logic clk_sys = 1'b0, arst_n = 1'b0, sampleClock = 1'b0, stall = 1'b0;
   logic rangeOrExtctlSelect = 1'b0, rangeOrExtctlSelectMid = 1'b0, calTrigger = 1'b0;
   logic outputSwingSelect = 1'b0, outputEdgeSelect = 1'b0, outputEdgeSelectMid = 1'b0;
   logic outputClockResync = 1'b0, powerDownInput = 1'b0;
   logic [SAMPLE_W-1:0] sampleCode = 8'h00;
   logic [SAMPLE_W-1:0] outputLaneA, outputLaneB, outputLaneC, outputLaneD;
   logic laneReady, laneValid, outputDataClock, calStart, powerDownActive, extendedMode;
   logic fullScale800, outputSwingHigh, ddrMode, demux2Mode, sampleOverrun;
   logic [CFG_W-1:0] configWord;
   logic [31:0] lastWord;
   logic [15:0] words, held;
   int mismatches = 0, comparisons = 0, cycles = 0, overruns = 0, cals = 0;

   acpod_top acpod_top_inst (.clk_sys, .arst_n, .sampleClock, .sampleCode,
      .rangeOrExtctlSelect, .rangeOrExtctlSelectMid, .outputSwingSelect, .outputEdgeSelect,
      .outputEdgeSelectMid, .outputClockResync, .powerDownInput, .calTrigger, .laneReady,
      .outputLaneA, .outputLaneB, .outputLaneC, .outputLaneD, .laneValid, .outputDataClock,
      .calStart, .powerDownActive, .extendedMode, .fullScale800, .outputSwingHigh, .ddrMode,
      .demux2Mode, .sampleOverrun, .configWord);
   acpod_capture_model acpod_capture_model_inst (.clk_sys, .arst_n, .stall, .laneValid,
      .outputLaneA, .outputLaneB, .outputLaneC, .outputLaneD, .laneReady, .lastWord, .words);

   always #10 clk_sys = ~clk_sys;

   task automatic test_done();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   always @(posedge clk_sys) begin
      cycles++;
      if (sampleOverrun === 1'b1) overruns++;
      if (calStart === 1'b1) cals++;
      if (cycles == 6000) begin
         mismatches++;
         $display("Error at %0t: timeout", $time);
         test_done();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic sample(input logic [7:0] code);
      sampleCode = code;
      tick(1);
      sampleClock = ~sampleClock;
      tick(3);
   endtask : sample

   task automatic send4(input logic [7:0] base);
      for (int i = 0; i < 4; i++) sample(base + 8'(i));
   endtask : send4

   task automatic serial(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         outputEdgeSelect = w[i];
         tick(3);
         outputSwingSelect = 1'b1;
         tick(3);
         outputSwingSelect = 1'b0;
      end
      tick(4);
   endtask : serial

   task automatic wait_word();
      int t;
      held = words;
      t = 0;
      while (words === held && t < 100) begin
         tick(1);
         t++;
      end
      if (words === held) begin
         mismatches++;
         $display("Error at %0t: no lane word", $time);
      end
   endtask : wait_word

   task automatic sleep_pulse();
      powerDownInput = 1'b1;
      tick(6);
      check(powerDownActive, 1'b1);
      powerDownInput = 1'b0;
      tick(6);
   endtask : sleep_pulse

   initial begin
      tick(8);
      arst_n = 1'b1;
      tick(4);
      check(configWord, 16'h0000);
      rangeOrExtctlSelect = 1'b1;
      tick(6);
      check(fullScale800, 1'b1);
      rangeOrExtctlSelect = 1'b0;
      outputEdgeSelectMid = 1'b1;
      tick(6);
      check({fullScale800, ddrMode}, 2'h1);
      outputEdgeSelectMid = 1'b0;
      sleep_pulse();
      $display("Test pins finished");
      send4(8'h7E);
      wait_word();
      check(lastWord, 32'hFEFF0001);
      stall = 1'b1;
      for (int g = 1; g < 4; g++) send4(8'(g) * 8'h10);
      check(overruns != 0, 1'b1);
      stall = 1'b0;
      wait_word();
      check(lastWord, 32'h90919293);
      check(outputDataClock, 1'b1);
      $display("Test stream finished");
      outputClockResync = 1'b1;
      tick(6);
      check(outputDataClock, 1'b0);
      held = words;
      send4(8'h40);
      tick(10);
      check(words, held);
      sleep_pulse();
      outputClockResync = 1'b0;
      sleep_pulse();
      $display("Test resync finished");
      rangeOrExtctlSelectMid = 1'b1;
      tick(6);
      check(extendedMode, 1'b1);
      check(outputSwingHigh, 1'b1);
      serial(16'h000D);
      check(configWord, 16'h000D);
      check({fullScale800, ddrMode, demux2Mode}, 3'h7);
      sample(8'h05);
      sample(8'h85);
      wait_word();
      check(lastWord, 32'h00008505);
      serial(16'h400D);
      outputClockResync = 1'b1;
      tick(6);
      sample(8'h01);
      sample(8'h02);
      wait_word();
      check(lastWord, 32'h00008182);
      outputClockResync = 1'b0;
      rangeOrExtctlSelectMid = 1'b0;
      tick(6);
      $display("Test extended finished");
      for (int i = 0; i < 160; i++) sample(8'h00);
      calTrigger = 1'b1;
      for (int i = 0; i < 158; i++) sample(8'h00);
      tick(8);
      check(cals, 0);
      sample(8'h00);
      sample(8'h00);
      tick(8);
      check(cals, 1);
      check(outputDataClock, 1'b0);
      check(lastWord, 32'h80808080);
      $display("Test calibration finished");
      test_done();
   end
endmodule : acpod_top_tb

bind acpod_top acpod_top_asserts acpod_top_asserts_inst (.clk_sys, .arst_n,
   .rangeOrExtctlSelect, .rangeOrExtctlSelectMid, .outputEdgeSelectMid, .outputClockResync,
   .powerDownInput, .outputLaneA, .outputLaneB, .laneValid, .outputDataClock, .calStart,
   .powerDownActive, .extendedMode, .fullScale800, .ddrMode, .demux2Mode, .configWord);
